/* File: common/pefg_pkg.sv */
/*
  Constants for the port E, F and G pin override block.
  Assumes one 25 MHz clock and an asynchronous active-low reset.
*/
// Functional notes
// - PE3 carries timer3 compare A output.
// - PE2 clock pin only in synchronous mode.
// - Sync mode sets PE2 output value from clock output; DDR sets direction.
// - Receiver enable forces PE0 to input.
// - Receiver-enabled PE0 pull-up follows port data outside programming mode.
// - Transmitter forces PE1 output, data, pull-up off outside programming mode.
// - Programming mode uses PE1 out, PE0 in.
// - Interrupts enable input; PE5/PE4 carry compares.
// - Legacy mode keeps port F input only.
// - Test port pull-ups stay on through reset.
// - Test port owns PF7..PF4 with fixed overrides.
// - Test data output driven only while shifting.
// - Tester clocks and steers the test controller.
// - PF3..PF0 have no digital overrides outside legacy mode.
// - Legacy mode gives port G alternate functions.
// - Timer0 async select frees PG4, PG3.
// - PG2 carries the address latch strobe.
package pefg_pkg;
  localparam int unsigned PE_RXD = 0;
  localparam int unsigned PE_TXD = 1;
  localparam int unsigned PE_XCK = 2;
  localparam int unsigned PE_OCA = 3;
  localparam int unsigned PE_OCB = 4;
  localparam int unsigned PE_OCC = 5;
  localparam int unsigned PF_TCK = 4;
  localparam int unsigned PF_TMS = 5;
  localparam int unsigned PF_TDO = 6;
  localparam int unsigned PF_TDI = 7;
  localparam int unsigned PG_WRS = 0;
  localparam int unsigned PG_RDS = 1;
  localparam int unsigned PG_ALE = 2;
  localparam int unsigned PG_OSC2 = 3;
  localparam int unsigned PG_OSC1 = 4;
  localparam logic [3:0] PF_TEST_PULL = 4'hb;
  localparam logic [7:0] OE_B_RST = 8'hff;
  localparam logic [7:0] PF_PULL_RST = 8'hb0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PINE = 4'h1;
  localparam logic [3:0] OFS_PINF = 4'h2;
  localparam logic [3:0] OFS_PING = 4'h3;
  localparam int unsigned CB_PUD = 0;
  localparam int unsigned CB_TEST = 1;
  localparam int unsigned CB_ASYNC = 2;
  localparam int unsigned CB_XMEM = 3;
endpackage

/* File: common/pefg_ovr_if.sv */
/*
  Override pairs for one 8-bit port.
  Assumes the top module drives them and a pin cell consumes them.
*/
`timescale 1ns/1ps
interface pefg_ovr_if;
  logic [7:0] pullup_override_enable;
  logic [7:0] pullup_override_value;
  logic [7:0] direction_override_enable;
  logic [7:0] direction_override_value;
  logic [7:0] outvalue_override_enable;
  logic [7:0] outvalue_override_value;
  logic [7:0] input_enable_override_enable;
  logic [7:0] input_enable_override_value;
  modport src (output pullup_override_enable, pullup_override_value, direction_override_enable,
    direction_override_value, outvalue_override_enable, outvalue_override_value,
    input_enable_override_enable, input_enable_override_value);
  modport dst (input pullup_override_enable, pullup_override_value, direction_override_enable,
    direction_override_value, outvalue_override_enable, outvalue_override_value,
    input_enable_override_enable, input_enable_override_value);
endinterface

/* File: design/pefg_pin_cell.sv */
/*
  Per-bit merge of override pairs with the port registers.
  Assumes pure combinational use; the caller registers the results.
*/
`timescale 1ns/1ps
module pefg_pin_cell
  import pefg_pkg::*;
(
  pefg_ovr_if.dst ovr,
  input wire logic [7:0] port_data,
  input wire logic [7:0] port_dir,
  input wire logic [7:0] pin_in,
  input wire logic pullup_dis,
  output logic [7:0] pull_en,
  output logic [7:0] dir_en,
  output logic [7:0] out_val,
  output logic [7:0] din
);
  // ----------------------------------------
  // Override selection per bit.
  // ----------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_bit
    logic pull_norm;
    logic die;
    assign pull_norm = port_data[i] & ~port_dir[i] & ~pullup_dis;
    assign pull_en[i] = ovr.pullup_override_enable[i] ? ovr.pullup_override_value[i] : pull_norm;
    assign dir_en[i] = ovr.direction_override_enable[i] ? ovr.direction_override_value[i] : port_dir[i];
    assign out_val[i] = ovr.outvalue_override_enable[i] ? ovr.outvalue_override_value[i] : port_data[i];
    assign die = ovr.input_enable_override_enable[i] ? ovr.input_enable_override_value[i] : 1'b1;
    assign din[i] = pin_in[i] & die;
  end
endmodule // pefg_pin_cell

/* File: design/pefg_top.sv */
/*
  Pin override logic for ports E, F and G, with a small control register.
  Assumes synchronous pin inputs and peripherals that present their own enables.
*/
`timescale 1ns/1ps
module pefg_top
  import pefg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic legacy_mode,
  input wire logic [7:0] port_e,
  input wire logic [7:0] ddr_e,
  input wire logic [7:0] pin_e,
  input wire logic [7:0] port_f,
  input wire logic [7:0] ddr_f,
  input wire logic [7:0] pin_f,
  input wire logic [7:0] port_g,
  input wire logic [7:0] ddr_g,
  input wire logic [7:0] pin_g,
  input wire logic timer3_compare_a_out,
  input wire logic timer3_compare_b_out,
  input wire logic timer3_compare_c_out,
  input wire logic [2:0] compare_en,
  input wire logic usart0_sync_select,
  input wire logic usart0_clock_out,
  input wire logic usart0_transmitter_enable,
  input wire logic usart0_receiver_enable,
  input wire logic usart0_transmit_out,
  input wire logic serial_prog_mode,
  input wire logic serial_prog_data_out,
  input wire logic [3:0] ext_irq_enable,
  input wire logic tap_instruction_shifting,
  input wire logic tap_data_shifting,
  input wire logic tap_serial_out,
  input wire logic xmem_ale,
  input wire logic xmem_rd,
  input wire logic xmem_wr,
  output logic [7:0] pe_pullup_q,
  output logic [7:0] pe_out_q,
  output logic [7:0] pe_oe_b_q,
  output logic [7:0] pf_pullup_q,
  output logic [7:0] pf_out_q,
  output logic [7:0] pf_oe_b_q,
  output logic [7:0] pg_pullup_q,
  output logic [7:0] pg_out_q,
  output logic [7:0] pg_oe_b_q,
  output logic usart0_receive_in_q,
  output logic usart0_ext_clock_q,
  output logic serial_prog_data_in_q,
  output logic [3:0] ext_irq_in_q,
  output logic capture3_input_q,
  output logic timer3_clock_input_q,
  output logic tap_tdi_q,
  output logic tap_tms_q,
  output logic tap_tck_q
);
  pefg_ovr_if ovr_e ();
  pefg_ovr_if ovr_f ();
  pefg_ovr_if ovr_g ();
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] rdata_d;
  logic global_pullup_disable, test_en, async0, xmem;
  logic [7:0] e_pu, e_dir, e_out, e_din;
  logic [7:0] f_pu, f_dir, f_out, f_din;
  logic [7:0] g_pu, g_dir, g_out, g_din;
  logic [7:0] pe_pu_d, pe_out_d, pe_oe_d, pf_pu_d, pf_out_d, pf_oe_d;
  logic [7:0] pg_pu_d, pg_out_d, pg_oe_d;
  logic rxd_d, xck_d, pdi_d, icp_d, t3_d, tdi_d, tms_d, tck_d;
  logic [3:0] irq_d;

  assign global_pullup_disable = ctrl_q[CB_PUD];
  assign test_en = ctrl_q[CB_TEST];
  assign async0 = ctrl_q[CB_ASYNC];
  assign xmem = ctrl_q[CB_XMEM] | legacy_mode;

  // ----------------------------------------
  // Port E overrides.
  // ----------------------------------------
  always_comb begin
    ovr_e.pullup_override_enable = '0;
    ovr_e.pullup_override_value = '0;
    ovr_e.direction_override_enable = '0;
    ovr_e.direction_override_value = '0;
    ovr_e.outvalue_override_enable = '0;
    ovr_e.outvalue_override_value = '0;
    ovr_e.input_enable_override_enable = '0;
    ovr_e.input_enable_override_value = '0;
    ovr_e.input_enable_override_enable[7:4] = ext_irq_enable;
    ovr_e.input_enable_override_value[7:4] = 4'hf;
    ovr_e.outvalue_override_enable[PE_OCC] = compare_en[2];
    ovr_e.outvalue_override_value[PE_OCC] = timer3_compare_c_out;
    ovr_e.outvalue_override_enable[PE_OCB] = compare_en[1];
    ovr_e.outvalue_override_value[PE_OCB] = timer3_compare_b_out;
    ovr_e.outvalue_override_enable[PE_OCA] = compare_en[0];
    ovr_e.outvalue_override_value[PE_OCA] = timer3_compare_a_out;
    ovr_e.outvalue_override_enable[PE_XCK] = usart0_sync_select;
    ovr_e.outvalue_override_value[PE_XCK] = usart0_clock_out;
    if (serial_prog_mode) begin
      ovr_e.direction_override_enable[PE_TXD] = 1'b1;
      ovr_e.direction_override_value[PE_TXD] = 1'b1;
      ovr_e.outvalue_override_enable[PE_TXD] = 1'b1;
      ovr_e.outvalue_override_value[PE_TXD] = serial_prog_data_out;
      ovr_e.direction_override_enable[PE_RXD] = 1'b1;
    end else begin
      ovr_e.pullup_override_enable[PE_TXD] = usart0_transmitter_enable;
      ovr_e.direction_override_enable[PE_TXD] = usart0_transmitter_enable;
      ovr_e.direction_override_value[PE_TXD] = 1'b1;
      ovr_e.outvalue_override_enable[PE_TXD] = usart0_transmitter_enable;
      ovr_e.outvalue_override_value[PE_TXD] = usart0_transmit_out;
      ovr_e.pullup_override_enable[PE_RXD] = usart0_receiver_enable;
      ovr_e.pullup_override_value[PE_RXD] = port_e[PE_RXD] & ~global_pullup_disable;
      ovr_e.direction_override_enable[PE_RXD] = usart0_receiver_enable;
    end
  end

  // ----------------------------------------
  // Port F overrides.
  // ----------------------------------------
  always_comb begin
    ovr_f.pullup_override_enable = '0;
    ovr_f.pullup_override_value = '0;
    ovr_f.direction_override_enable = '0;
    ovr_f.direction_override_value = '0;
    ovr_f.outvalue_override_enable = '0;
    ovr_f.outvalue_override_value = '0;
    ovr_f.input_enable_override_enable = '0;
    ovr_f.input_enable_override_value = '0;
    if (test_en) begin
      ovr_f.pullup_override_enable[7:4] = 4'hf;
      ovr_f.pullup_override_value[7:4] = PF_TEST_PULL;
      ovr_f.direction_override_enable[7:4] = 4'hf;
      ovr_f.direction_override_value[PF_TDO] = tap_instruction_shifting | tap_data_shifting;
      ovr_f.outvalue_override_enable[PF_TDO] = 1'b1;
      ovr_f.outvalue_override_value[PF_TDO] = tap_serial_out;
      ovr_f.input_enable_override_enable[7:4] = 4'hf;
    end
    if (legacy_mode) begin
      ovr_f.direction_override_enable = 8'hff;
      ovr_f.direction_override_value = 8'h00;
    end
  end

  // ----------------------------------------
  // Port G overrides.
  // ----------------------------------------
  always_comb begin
    ovr_g.pullup_override_enable = '0;
    ovr_g.pullup_override_value = '0;
    ovr_g.direction_override_enable = '0;
    ovr_g.direction_override_value = '0;
    ovr_g.outvalue_override_enable = '0;
    ovr_g.outvalue_override_value = '0;
    ovr_g.input_enable_override_enable = '0;
    ovr_g.input_enable_override_value = '0;
    ovr_g.pullup_override_enable[2:0] = {3{xmem}};
    ovr_g.direction_override_enable[2:0] = {3{xmem}};
    ovr_g.direction_override_value[2:0] = 3'h7;
    ovr_g.outvalue_override_enable[2:0] = {3{xmem}};
    ovr_g.outvalue_override_value[PG_ALE] = xmem_ale;
    ovr_g.outvalue_override_value[PG_RDS] = xmem_rd;
    ovr_g.outvalue_override_value[PG_WRS] = xmem_wr;
    if (async0 || legacy_mode) begin
      ovr_g.pullup_override_enable[PG_OSC1:PG_OSC2] = 2'h3;
      ovr_g.direction_override_enable[PG_OSC1:PG_OSC2] = 2'h3;
      ovr_g.input_enable_override_enable[PG_OSC1:PG_OSC2] = 2'h3;
    end
  end

  pefg_pin_cell u_cell_e (.ovr(ovr_e), .port_data(port_e), .port_dir(ddr_e), .pin_in(pin_e),
    .pullup_dis(global_pullup_disable), .pull_en(e_pu), .dir_en(e_dir), .out_val(e_out), .din(e_din));
  pefg_pin_cell u_cell_f (.ovr(ovr_f), .port_data(port_f), .port_dir(ddr_f), .pin_in(pin_f),
    .pullup_dis(global_pullup_disable), .pull_en(f_pu), .dir_en(f_dir), .out_val(f_out), .din(f_din));
  pefg_pin_cell u_cell_g (.ovr(ovr_g), .port_data(port_g), .port_dir(ddr_g), .pin_in(pin_g),
    .pullup_dis(global_pullup_disable), .pull_en(g_pu), .dir_en(g_dir), .out_val(g_out), .din(g_din));

  // ----------------------------------------
  // Next values for pins, peripherals and registers.
  // ----------------------------------------
  always_comb begin
    pe_pu_d = e_pu;
    pe_out_d = e_out;
    pe_oe_d = ~e_dir;
    pf_pu_d = f_pu;
    pf_out_d = f_out;
    pf_oe_d = ~f_dir;
    pg_pu_d = g_pu;
    pg_out_d = g_out;
    pg_oe_d = ~g_dir;
    rxd_d = e_din[PE_RXD];
    pdi_d = serial_prog_mode & e_din[PE_RXD];
    xck_d = usart0_sync_select & e_din[PE_XCK];
    irq_d = e_din[7:4];
    icp_d = e_din[7];
    t3_d = e_din[6];
    tdi_d = test_en & pin_f[PF_TDI];
    tms_d = test_en & pin_f[PF_TMS];
    tck_d = test_en & pin_f[PF_TCK];
    ctrl_d = ctrl_q;
    if (reg_wr && reg_addr == OFS_CTRL) begin
      ctrl_d = {4'h0, reg_wdata[3:0]};
    end
    rdata_d = 8'h00;
    if (reg_rd && reg_addr == OFS_CTRL) begin
      rdata_d = ctrl_q;
    end else if (reg_rd && reg_addr == OFS_PINE) begin
      rdata_d = e_din;
    end else if (reg_rd && reg_addr == OFS_PINF) begin
      rdata_d = f_din;
    end else if (reg_rd && reg_addr == OFS_PING) begin
      rdata_d = g_din;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pe_pullup_q <= '0;
      pe_out_q <= '0;
      pe_oe_b_q <= OE_B_RST;
      pf_pullup_q <= PF_PULL_RST;
      pf_out_q <= '0;
      pf_oe_b_q <= OE_B_RST;
      pg_pullup_q <= '0;
      pg_out_q <= '0;
      pg_oe_b_q <= OE_B_RST;
      usart0_receive_in_q <= 1'b0;
      usart0_ext_clock_q <= 1'b0;
      serial_prog_data_in_q <= 1'b0;
      ext_irq_in_q <= '0;
      capture3_input_q <= 1'b0;
      timer3_clock_input_q <= 1'b0;
      tap_tdi_q <= 1'b0;
      tap_tms_q <= 1'b0;
      tap_tck_q <= 1'b0;
      ctrl_q <= CTRL_RST;
      reg_rdata_q <= '0;
    end else begin
      pe_pullup_q <= pe_pu_d;
      pe_out_q <= pe_out_d;
      pe_oe_b_q <= pe_oe_d;
      pf_pullup_q <= pf_pu_d;
      pf_out_q <= pf_out_d;
      pf_oe_b_q <= pf_oe_d;
      pg_pullup_q <= pg_pu_d;
      pg_out_q <= pg_out_d;
      pg_oe_b_q <= pg_oe_d;
      usart0_receive_in_q <= rxd_d;
      usart0_ext_clock_q <= xck_d;
      serial_prog_data_in_q <= pdi_d;
      ext_irq_in_q <= irq_d;
      capture3_input_q <= icp_d;
      timer3_clock_input_q <= t3_d;
      tap_tdi_q <= tdi_d;
      tap_tms_q <= tms_d;
      tap_tck_q <= tck_d;
      ctrl_q <= ctrl_d;
      reg_rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  oca_out_a: assert property (compare_en[0] && ddr_e[PE_OCA] |=>
    !pe_oe_b_q[PE_OCA] && pe_out_q[PE_OCA] == $past(timer3_compare_a_out))
    else $error("compare A not on PE3");
  xck_out_a: assert property (usart0_sync_select |=> pe_out_q[PE_XCK] == $past(usart0_clock_out))
    else $error("sync clock not on PE2");
  rxd_input_a: assert property (usart0_receiver_enable |=> pe_oe_b_q[PE_RXD])
    else $error("PE0 driven while receiving");
  rxd_pull_a: assert property (usart0_receiver_enable && !serial_prog_mode |=>
    pe_pullup_q[PE_RXD] == ($past(port_e[PE_RXD]) & ~$past(global_pullup_disable)))
    else $error("PE0 pull-up wrong");
  txd_drive_a: assert property (usart0_transmitter_enable && !serial_prog_mode |=>
    !pe_oe_b_q[PE_TXD] && !pe_pullup_q[PE_TXD] && pe_out_q[PE_TXD] == $past(usart0_transmit_out))
    else $error("PE1 not transmitting");
  test_pull_a: assert property (test_en |=> pf_pullup_q[7:4] == PF_TEST_PULL)
    else $error("test port pull-ups wrong");
  tdo_float_a: assert property (test_en && !tap_instruction_shifting && !tap_data_shifting |=>
    pf_oe_b_q[PF_TDO])
    else $error("test data out driven idle");
  tdo_drive_a: assert property (test_en && tap_data_shifting && !legacy_mode |=>
    !pf_oe_b_q[PF_TDO] && pf_out_q[PF_TDO] == $past(tap_serial_out))
    else $error("test data out not driven");
  legacy_f_a: assert property (legacy_mode |=> pf_oe_b_q == 8'hff)
    else $error("port F driven in legacy mode");
  osc_free_a: assert property (async0 |=> pg_oe_b_q[4:3] == 2'h3 && pg_pullup_q[4:3] == 2'h0)
    else $error("oscillator pins not released");
  ale_drive_a: assert property (xmem |=> !pg_oe_b_q[PG_ALE] && pg_out_q[PG_ALE] == $past(xmem_ale))
    else $error("latch strobe not on PG2");
  adc_plain_a: assert property (rst_b && !legacy_mode |=> pf_oe_b_q[3:0] == ~$past(ddr_f[3:0]))
    else $error("PF3..PF0 overridden");

  test_shift_c: cover property (test_en && tap_instruction_shifting ##1 test_en && tap_data_shifting);
  usart_both_c: cover property (usart0_transmitter_enable && usart0_receiver_enable);
  prog_mode_c: cover property (serial_prog_mode && usart0_transmitter_enable);
  xmem_async_c: cover property (xmem && async0);
endmodule // pefg_top

/* File: test/pefg_pin_model.sv */
/*
  Pin model for one 8-bit port of the override block.
  Assumes the bench supplies what the far side drives while the block releases a pin.
*/
`timescale 1ns/1ps
module pefg_pin_model (
  input wire logic [7:0] oe_b,
  input wire logic [7:0] drive,
  input wire logic [7:0] ext,
  output logic [7:0] pin
);
  // ----------------------------------------
  // Pin level
  // ----------------------------------------
  // A driven pin shows the block's value; a released pin shows the far side.
  // The far side never moves a port F pin that the block drives.
  assign pin = (oe_b & ext) | (~oe_b & drive);
endmodule // pefg_pin_model

/* File: test/pefg_top_tb.sv */
/*
  Self-checking bench for the port E, F and G override block.
  Assumes the pin model files are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pefg_top_tb;
  import pefg_pkg::*;
  typedef struct {int due; int sel; logic [7:0] m; logic [7:0] v;} pefg_tb_note_t;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, rst_b, reg_wr, reg_rd, legacy_mode, timer3_compare_a_out, timer3_compare_b_out;
  logic timer3_compare_c_out, usart0_sync_select, usart0_clock_out, usart0_transmitter_enable;
  logic usart0_receiver_enable, usart0_transmit_out, serial_prog_mode, serial_prog_data_out;
  logic tap_instruction_shifting, tap_data_shifting, tap_serial_out, xmem_ale, xmem_rd, xmem_wr;
  logic [3:0] reg_addr, ext_irq_enable, ext_irq_in_q;
  logic [2:0] compare_en;
  logic [7:0] reg_wdata, reg_rdata_q, port_e, ddr_e, port_f, ddr_f, port_g, ddr_g, ext_e, ext_f, ext_g;
  logic [7:0] pin_e, pin_f, pin_g, pe_pullup_q, pe_out_q, pe_oe_b_q, pf_pullup_q, pf_out_q, pf_oe_b_q;
  logic [7:0] pg_pullup_q, pg_out_q, pg_oe_b_q;
  logic usart0_receive_in_q, usart0_ext_clock_q, serial_prog_data_in_q, capture3_input_q;
  logic timer3_clock_input_q, tap_tdi_q, tap_tms_q, tap_tck_q;
  logic [31:0] seed, r, r2;
  logic [1:0] sh;
  int cyc = 0;
  int base;
  int num_errors = 0;
  int samples_checked = 0;
  pefg_tb_note_t notes[$];
  pefg_top pefg_top_i (.*);
  pefg_pin_model pefg_pin_model_e_i (.oe_b(pe_oe_b_q), .drive(pe_out_q), .ext(ext_e), .pin(pin_e));
  pefg_pin_model pefg_pin_model_f_i (.oe_b(pf_oe_b_q), .drive(pf_out_q), .ext(ext_f), .pin(pin_f));
  pefg_pin_model pefg_pin_model_g_i (.oe_b(pg_oe_b_q), .drive(pg_out_q), .ext(ext_g), .pin(pin_g));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] obs(input int sel);
    case (sel)
      0: return pe_pullup_q;
      1: return pe_out_q;
      2: return pe_oe_b_q;
      3: return pf_pullup_q;
      4: return pf_out_q;
      5: return pf_oe_b_q;
      6: return pg_pullup_q;
      7: return pg_out_q;
      8: return pg_oe_b_q;
      9: return reg_rdata_q;
      10: return {usart0_receive_in_q, usart0_ext_clock_q, serial_prog_data_in_q, capture3_input_q,
        timer3_clock_input_q, tap_tdi_q, tap_tms_q, tap_tck_q};
      default: return {4'h0, ext_irq_in_q};
    endcase
  endfunction
  task automatic want(input int sel, input logic [7:0] m, input logic [7:0] v, input int lat);
    notes.push_back('{base + 1 + lat, sel, m, v});
  endtask
  task automatic drive();
    @(posedge clk);
    base = cyc;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [7:0] v);
    drive();
    reg_addr <= a;
    reg_rd <= 1'b1;
    want(9, 8'hff, v, 1);
    want(9, 8'hff, 8'h00, 2);
    @(posedge clk);
    reg_rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic idle();
    {legacy_mode, usart0_sync_select, usart0_clock_out, usart0_transmitter_enable} <= 4'h0;
    {usart0_receiver_enable, usart0_transmit_out, serial_prog_mode, serial_prog_data_out} <= 4'h0;
    {tap_instruction_shifting, tap_data_shifting, tap_serial_out, xmem_ale, xmem_rd, xmem_wr} <= 6'h00;
    {timer3_compare_a_out, timer3_compare_b_out, timer3_compare_c_out} <= 3'h0;
    compare_en <= 3'h0;
    ext_irq_enable <= 4'h0;
  endtask
  task automatic stop_test();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Monitor and watchdog
  // ----------------------------------------
  always @(negedge clk) begin
    for (int i = notes.size() - 1; i >= 0; i--) begin
      if (notes[i].due == cyc) begin
        `CHK(obs(notes[i].sel) & notes[i].m, notes[i].v & notes[i].m)
        notes.delete(i);
      end
    end
  end
  initial begin
    #(3000 * 40);
    num_errors++;
    stop_test();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seed = 32'h1cef;
    rst_b = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0000;
    {port_e, ddr_e, port_f, ddr_f, port_g, ddr_g, ext_e, ext_f, ext_g} = 72'h0;
    idle();
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      drive();
      r = rnd();
      r2 = rnd();
      {ddr_f, port_f, ddr_e, port_e} <= r;
      {ext_f, ext_e, ddr_g, port_g} <= r2;
      want(1, 8'hff, r[7:0], 1);
      want(2, 8'hff, ~r[15:8], 1);
      want(0, 8'hff, r[7:0] & ~r[15:8], 1);
      want(4, 8'hff, r[23:16], 1);
      want(5, 8'hff, ~r[31:24], 1);
      want(7, 8'h1f, r2[7:0], 1);
      want(8, 8'h1f, ~r2[15:8], 1);
      settle();
      reg_read(OFS_PINE, (r[15:8] & r[7:0]) | (~r[15:8] & r2[23:16]));
    end
    for (int b = 0; b < 2; b++) begin
      drive();
      ddr_e <= 8'h01;
      port_e <= 8'h02;
      usart0_transmitter_enable <= 1'b1;
      usart0_transmit_out <= b[0];
      want(2, 8'h02, 8'h00, 1);
      want(1, 8'h02, {6'h00, b[0], 1'b0}, 1);
      want(0, 8'h02, 8'h00, 1);
      settle();
    end
    drive();
    idle();
    usart0_receiver_enable <= 1'b1;
    port_e <= 8'h01;
    ext_e <= 8'h01;
    want(2, 8'h01, 8'h01, 1);
    want(0, 8'h01, 8'h01, 1);
    want(10, 8'h80, 8'h80, 2);
    settle();
    reg_write(OFS_CTRL, 8'h01);
    drive();
    want(0, 8'h01, 8'h00, 1);
    settle();
    reg_write(OFS_CTRL, 8'hf0);
    reg_read(OFS_CTRL, 8'h00);
    reg_read(4'hc, 8'h00);
    drive();
    idle();
    serial_prog_mode <= 1'b1;
    serial_prog_data_out <= 1'b1;
    usart0_transmitter_enable <= 1'b1;
    want(1, 8'h02, 8'h02, 1);
    want(2, 8'h03, 8'h01, 1);
    want(10, 8'h20, 8'h20, 2);
    settle();
    for (int d = 0; d < 2; d++) begin
      drive();
      idle();
      usart0_sync_select <= 1'b1;
      usart0_clock_out <= 1'b1;
      ddr_e <= {5'h00, d[0], 2'h0};
      ext_e <= 8'h00;
      want(1, 8'h04, 8'h04, 1);
      want(2, 8'h04, {5'h00, ~d[0], 2'h0}, 1);
      want(10, 8'h40, {1'b0, d[0], 6'h00}, 2);
      settle();
    end
    drive();
    idle();
    r = rnd();
    {timer3_compare_c_out, timer3_compare_b_out, timer3_compare_a_out} <= r[10:8];
    compare_en <= 3'h7;
    ext_irq_enable <= 4'hf;
    ddr_e <= 8'h38;
    ext_e <= r[7:0];
    want(1, 8'h38, {2'h0, r[10:8], 3'h0}, 1);
    want(2, 8'h38, 8'h00, 1);
    want(11, 8'h0f, {4'h0, r[7:6], r[10:9]}, 2);
    want(10, 8'h18, {3'h0, r[7:6], 3'h0}, 2);
    settle();
    reg_write(OFS_CTRL, 8'h02);
    for (int i = 0; i < 4; i++) begin
      drive();
      idle();
      sh = i[1:0];
      ddr_f <= 8'hff;
      port_f <= 8'hff;
      {tap_data_shifting, tap_instruction_shifting} <= sh;
      tap_serial_out <= sh[0];
      ext_f <= {sh[0], 1'b0, sh[1], 1'b1, 4'h0};
      want(3, 8'hff, 8'hb0, 1);
      want(5, 8'hff, {1'b1, ~(|sh), 2'h3, 4'h0}, 1);
      want(4, 8'h4f, {1'b0, sh[0], 2'h0, 4'hf}, 1);
      want(10, 8'h07, {5'h00, sh[0], sh[1], 1'b1}, 2);
      settle();
    end
    reg_read(OFS_PINF, 8'h0f);
    drive();
    rst_b <= 1'b0;
    want(3, 8'hb0, 8'hb0, 1);
    settle();
    drive();
    rst_b <= 1'b1;
    legacy_mode <= 1'b1;
    ddr_g <= 8'h00;
    port_g <= 8'hff;
    {xmem_ale, xmem_rd, xmem_wr} <= 3'h5;
    want(5, 8'hff, 8'hff, 2);
    want(8, 8'h1f, 8'h18, 2);
    want(7, 8'h07, 8'h05, 2);
    want(6, 8'h18, 8'h00, 2);
    settle();
    reg_write(OFS_CTRL, 8'h0c);
    for (int a = 0; a < 2; a++) begin
      drive();
      legacy_mode <= 1'b0;
      ddr_g <= 8'hff;
      ext_g <= 8'hff;
      xmem_ale <= a[0];
      want(8, 8'h1c, 8'h18, 1);
      want(6, 8'h18, 8'h00, 1);
      want(7, 8'h04, {5'h00, a[0], 2'h0}, 1);
      settle();
    end
    reg_read(OFS_PING, 8'he5);
    stop_test();
  end
endmodule // pefg_top_tb
